// ### oneshot_ctrl_pkg.sv
// Types shared by the one-shot terminate and reload control
package oneshot_ctrl_pkg;

  // One bit per one-shot output, A at bit 0 up to P at bit 15
  typedef logic [15:0] out_mask_t;

  // One bit per output of one trigger group (A..H or I..P)
  typedef logic [7:0] group_mask_t;

  // Avalon slave access phase
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } bus_phase_t;

endpackage

// ### oneshot_ctrl_properties.sv
// Concurrent checks on the one-shot terminate and reload control
`timescale 1ns/1ns
`include "oneshot_ctrl_regs.svh"

module oneshot_ctrl_properties (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic                          hw_standby,
  input wire logic                          sw_standby,
  input wire logic [2:0]                    avs_address,
  input wire logic                          avs_read,
  input wire logic                          avs_write,
  input wire logic [31:0]                   avs_readdata,
  input wire logic                          avs_waitrequest,
  input wire oneshot_ctrl_pkg::group_mask_t ch1_stop_trig,
  input wire oneshot_ctrl_pkg::group_mask_t ch2_stop_trig,
  input wire oneshot_ctrl_pkg::group_mask_t ch2_start_trig,
  input wire oneshot_ctrl_pkg::group_mask_t link_ch2,
  input wire oneshot_ctrl_pkg::out_mask_t   down_count_start_bits,
  input wire oneshot_ctrl_pkg::out_mask_t   start_bit_clr,
  input wire oneshot_ctrl_pkg::out_mask_t   counter_clr,
  input wire oneshot_ctrl_pkg::group_mask_t reload_load,
  input wire logic                          irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Bus access: one wait cycle, then back to waiting
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  property p_bus_answer;
    s_req |=> s_ans;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer timing wrong");

  // A clear needs a trigger on a running counter
  property p_stop_cause;
    start_bit_clr != 16'h0000 |-> (start_bit_clr & ~$past(
      {ch2_stop_trig, ch1_stop_trig} & down_count_start_bits)) == 16'h0000;
  endproperty
  a_stop_cause: assert property (p_stop_cause)
    else $error("clear without trigger");
  property p_clr_pair;
    counter_clr == start_bit_clr;
  endproperty
  a_clr_pair: assert property (p_clr_pair)
    else $error("counter clear differs from start bit clear");

  // Reload only for linked, idle counters with a start trigger
  property p_reload_cause;
    reload_load != 8'h00 |-> (reload_load & ~$past(ch2_start_trig
      & link_ch2 & ~down_count_start_bits[15:8])) == 8'h00;
  endproperty
  a_reload_cause: assert property (p_reload_cause)
    else $error("reload without cause");

  // Reserved and unmapped places read as zero
  property p_rsv_read;
    avs_read && !avs_waitrequest && avs_address == `OSC_IDX_RELOAD_EN
      |-> avs_readdata[6:0] == 7'h00 && avs_readdata[31:8] == 24'h000000;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved reload bits read nonzero");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > 3'h4
      |-> avs_readdata == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read nonzero");

  // Quiet outputs right after reset and after standby entry
  property p_reset_quiet;
    $past(rst) |-> !irq && start_bit_clr == 16'h0000
      && reload_load == 8'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs active after reset");
  property p_standby;
    hw_standby || sw_standby
      |=> (reload_load == 8'h00 && start_bit_clr == 16'h0000) [*2];
  endproperty
  a_standby: assert property (p_standby)
    else $error("strobe after standby");
endmodule // oneshot_ctrl_properties

// ### oneshot_ctrl_regs.svh
// Register offsets, field positions and reset values of the one-shot control
`ifndef ONESHOT_CTRL_REGS_SVH
`define ONESHOT_CTRL_REGS_SVH

// Word indices on the Avalon-MM slave (byte address is four times these)
`define OSC_IDX_FORCE_STOP   3'h0
`define OSC_IDX_RELOAD_EN    3'h1
`define OSC_IDX_RELOAD_VAL   3'h2
`define OSC_IDX_STATUS       3'h3
`define OSC_IDX_IRQ_MASK     3'h4

// Field positions
`define OSC_RELOAD_ALLOW_BIT 7
`define OSC_CH2_LSB          8
`define OSC_CH1_LSB          0

// Reset values
`define OSC_FORCE_STOP_RST   16'h0000
`define OSC_RELOAD_EN_RST    8'h00
`define OSC_RELOAD_VAL_RST   16'h0000
`define OSC_STATUS_RST       16'h0000
`define OSC_IRQ_MASK_RST     16'h0000

// Writable bit of the reload enable register; reserved bits 6..0 are masked off
`define OSC_RELOAD_EN_MASK   8'h80

`endif

// ### oneshot_terminate_reload_ctrl.sv
// Terminate gating and reload control for sixteen one-shot outputs
//
// Contract
// [RULE_01] Bits 15..8 let channel 2 stop triggers H..A end outputs P..I.
// [RULE_02] Bits 7..0 let channel 1 stop triggers H..A end outputs H..A.
// [RULE_03] A 0 enable bit, as after reset, ignores the trigger; 1 honours it.
// [RULE_04] A forced stop clears start bit and counter, sets the status flag.
// [RULE_05] Reload enable is 8 bits; its bit 7 allows reload of counters I..P.
// [RULE_06] If allowed, a channel 2 start trigger reloads its counter.
// [RULE_07] No reload for a counter unlinked to channel 2 or already counting.
// [RULE_08] Reload enable clears to zero on reset and on either standby entry.
// [RULE_09] Stop enable clears to zero on reset and in either standby mode.
// [RULE_10] Reload enable bits 6..0 read zero; software writes only zero.
// [RULE_11] One shared reload value serves all eight, each on its own trigger.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "oneshot_ctrl_regs.svh"

module oneshot_terminate_reload_ctrl (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      hw_standby,
  input  wire logic                      sw_standby,
  // Avalon-MM slave
  input  wire logic [2:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output      logic [31:0]               avs_readdata,
  output      logic                      avs_waitrequest,
  // Trigger inputs from the compare-match logic
  input  wire oneshot_ctrl_pkg::group_mask_t ch1_stop_trig,
  input  wire oneshot_ctrl_pkg::group_mask_t ch2_stop_trig,
  input  wire oneshot_ctrl_pkg::group_mask_t ch2_start_trig,
  input  wire oneshot_ctrl_pkg::group_mask_t link_ch2,
  input  wire oneshot_ctrl_pkg::out_mask_t   down_count_start_bits,
  // Commands toward the down-counters
  output      oneshot_ctrl_pkg::out_mask_t   start_bit_clr,
  output      oneshot_ctrl_pkg::out_mask_t   counter_clr,
  output      oneshot_ctrl_pkg::group_mask_t reload_load,
  output      logic [15:0]               shared_reload_value,
  output      logic                      irq
);

  // Register state
  oneshot_ctrl_pkg::out_mask_t   force_stop_enable_q;
  logic [7:0]                    reload_enable_q;
  logic [15:0]                   reload_value_q;
  oneshot_ctrl_pkg::out_mask_t   status_q;
  oneshot_ctrl_pkg::out_mask_t   status_d;
  oneshot_ctrl_pkg::out_mask_t   irq_mask_q;

  // Bus slave state
  oneshot_ctrl_pkg::bus_phase_t  phase_q;
  logic                          ack;
  logic                          req;
  logic                          wr_fire;
  logic [31:0]                   rd_mux;
  logic                          wr_force_stop;
  logic                          wr_reload_en;
  logic                          wr_reload_val;
  logic                          wr_status;
  logic                          wr_irq_mask;

  // Termination state
  oneshot_ctrl_pkg::out_mask_t   stop_trig;
  oneshot_ctrl_pkg::out_mask_t   stop_fire;
  oneshot_ctrl_pkg::out_mask_t   stop_q;
  logic                          standby;
  logic                          irq_q;

  // Standby entry clears the enables and reload value like reset does; the interrupt mask stays
  assign standby = hw_standby | sw_standby;

  // Avalon-MM slave: one wait cycle per access

  // A request is seen while idle; ack marks the cycle the master sees it
  assign req     = avs_read | avs_write;
  assign ack     = (phase_q == oneshot_ctrl_pkg::BUS_ACK);
  assign wr_fire = avs_write & ack;

  // Per-register write strobes, decoded once for every writer
  assign wr_force_stop = wr_fire & (avs_address == `OSC_IDX_FORCE_STOP);
  assign wr_reload_en  = wr_fire & (avs_address == `OSC_IDX_RELOAD_EN);
  assign wr_reload_val = wr_fire & (avs_address == `OSC_IDX_RELOAD_VAL);
  assign wr_status     = wr_fire & (avs_address == `OSC_IDX_STATUS);
  assign wr_irq_mask   = wr_fire & (avs_address == `OSC_IDX_IRQ_MASK);

  // Byte-lane merge of a write into an existing half-word
  // Only the low half-word exists, so lanes 2 and 3 are dropped
  function automatic logic [15:0] merge_be(
    input logic [15:0] old_val,
    input logic [15:0] new_val,
    input logic [1:0]  be
  );
    logic [15:0] r;
    r = old_val;
    for (int i = 0; i < 2; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Phase of the access; back to idle after the acknowledge edge
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_q <= oneshot_ctrl_pkg::BUS_IDLE;
    end
    else
    begin
      case (phase_q)
        oneshot_ctrl_pkg::BUS_IDLE:
        begin
          if (req)
          begin
            phase_q <= oneshot_ctrl_pkg::BUS_ACK;
          end
        end
        oneshot_ctrl_pkg::BUS_ACK:
        begin
          phase_q <= oneshot_ctrl_pkg::BUS_IDLE;
        end
        default:
        begin
          phase_q <= oneshot_ctrl_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest from a flop; low only in the acknowledge cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      avs_waitrequest <= ~((phase_q == oneshot_ctrl_pkg::BUS_IDLE) & req);
    end
  end

  // Read data selection; unmapped words read as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `OSC_IDX_FORCE_STOP:
      begin
        rd_mux = {16'h0000, force_stop_enable_q};
      end
      `OSC_IDX_RELOAD_EN:
      begin
        rd_mux = {24'h00_0000, reload_enable_q}; // [RULE_10]
      end
      `OSC_IDX_RELOAD_VAL:
      begin
        rd_mux = {16'h0000, reload_value_q};
      end
      `OSC_IDX_STATUS:
      begin
        rd_mux = {16'h0000, status_q};
      end
      `OSC_IDX_IRQ_MASK:
      begin
        rd_mux = {16'h0000, irq_mask_q};
      end
      default:
      begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // Read data is captured one edge early so it stands with waitrequest low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      avs_readdata <= 32'h0000_0000;
    end
    else if ((phase_q == oneshot_ctrl_pkg::BUS_IDLE) && avs_read)
    begin
      avs_readdata <= rd_mux;
    end
  end

  // Configuration registers

  // Terminate enables; zero after reset or standby
  always_ff @(posedge clk)
  begin
    if (rst || standby)
    begin
      force_stop_enable_q <= `OSC_FORCE_STOP_RST; // [RULE_09] [RULE_03]
    end
    else if (wr_force_stop)
    begin
      force_stop_enable_q <= merge_be(force_stop_enable_q,
                                      avs_writedata[15:0],
                                      avs_byteenable[1:0]);
    end
  end

  // Reload enable; reserved bits are never stored, so they read zero
  always_ff @(posedge clk)
  begin
    if (rst || standby)
    begin
      reload_enable_q <= `OSC_RELOAD_EN_RST; // [RULE_08]
    end
    else if (wr_reload_en && avs_byteenable[0])
    begin
      reload_enable_q <= avs_writedata[7:0] & `OSC_RELOAD_EN_MASK; // [RULE_10]
    end
  end

  // One reload value for all eight linked counters
  always_ff @(posedge clk)
  begin
    if (rst || standby)
    begin
      reload_value_q <= `OSC_RELOAD_VAL_RST; // [RULE_11]
    end
    else if (wr_reload_val)
    begin
      reload_value_q <= merge_be(reload_value_q,
                                 avs_writedata[15:0],
                                 avs_byteenable[1:0]);
    end
  end

  // Interrupt mask, same layout as the status flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_mask_q <= `OSC_IRQ_MASK_RST;
    end
    else if (wr_irq_mask)
    begin
      irq_mask_q <= merge_be(irq_mask_q,
                             avs_writedata[15:0],
                             avs_byteenable[1:0]);
    end
  end

  // Forced termination

  // Channel 2 triggers feed outputs I..P, channel 1 feeds A..H
  assign stop_trig[15:`OSC_CH2_LSB] = ch2_stop_trig; // [RULE_01]
  assign stop_trig[7:`OSC_CH1_LSB]  = ch1_stop_trig; // [RULE_02]

  // Only a running pulse can be cut short; a disabled bit ignores it
  assign stop_fire = stop_trig & force_stop_enable_q // [RULE_03]
                   & down_count_start_bits;

  // Clear strobes toward start bits and down-counters
  always_ff @(posedge clk)
  begin
    if (rst || standby)
    begin
      stop_q <= '0;
    end
    else
    begin
      stop_q <= stop_fire; // [RULE_04]
    end
  end

  // Both clears share one flop so they can never disagree
  assign start_bit_clr = stop_q;
  assign counter_clr   = stop_q;

  // Sticky status; a new event wins over a write-one clear
  always_comb
  begin
    status_d = status_q;
    if (wr_status)
    begin
      status_d = status_q & ~merge_be(16'h0000, avs_writedata[15:0],
                                      avs_byteenable[1:0]);
    end
    status_d = status_d | stop_fire; // [RULE_04]
  end

  // Status and mask survive standby; only reset clears them
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      status_q <= `OSC_STATUS_RST;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // Level interrupt, registered so the pin comes from a flop
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(status_d & irq_mask_q);
    end
  end

  // A mask change reaches the pin one cycle after the write
  assign irq = irq_q;

  // Reload of counters I..P

  // Running state of I..P comes from their start bits
  // Standby also clears the strobe flop inside the gate
  reload_gate #(
    .LANES (8)
  ) u_reload_gate (
    .clk          (clk),
    .rst          (rst),
    .clr          (standby),
    .reload_allow (reload_enable_q[`OSC_RELOAD_ALLOW_BIT]), // [RULE_05]
    .start_trig   (ch2_start_trig),                         // [RULE_06]
    .link_ch2     (link_ch2),                               // [RULE_07]
    .running      (down_count_start_bits[15:`OSC_CH2_LSB]),
    .load_q       (reload_load)
  );

  // Value travels straight from its register
  assign shared_reload_value = reload_value_q; // [RULE_11]

endmodule // oneshot_terminate_reload_ctrl

// ### oneshot_terminate_reload_ctrl_test.sv
// Self-checking bench for the one-shot terminate and reload control
`timescale 1ns/1ns

module oneshot_terminate_reload_ctrl_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hw_sb = 1'b0;
  logic        sw_sb = 1'b0;
  logic [2:0]  adr = 3'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wait_q;
  logic [7:0]  t1 = 8'h00, t2 = 8'h00, st = 8'h00, lnk = 8'h00;
  logic [15:0] run = 16'h0000;
  logic [15:0] sclr, cclr, rval;
  logic [7:0]  load;
  logic        irq;
  logic [31:0] q;
  int          fails = 0, compares = 0, cyc = 0;

  oneshot_terminate_reload_ctrl oneshot_terminate_reload_ctrl_i (
    .clk(clk), .rst(rst), .hw_standby(hw_sb), .sw_standby(sw_sb),
    .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdat), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(wait_q), .ch1_stop_trig(t1), .ch2_stop_trig(t2),
    .ch2_start_trig(st), .link_ch2(lnk), .down_count_start_bits(run),
    .start_bit_clr(sclr), .counter_clr(cclr), .reload_load(load),
    .shared_reload_value(rval), .irq(irq));

  // Clock, and a ceiling far above the under two hundred cycles needed
  always #50 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk); while (wait_q !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // One-cycle trigger pulse; strobes stand in the following cycle
  task automatic pulse(input logic [7:0] a, b, s, l,
                       input logic [15:0] r);
    @(posedge clk);
    t1 <= a;
    t2 <= b;
    st <= s;
    lnk <= l;
    run <= r;
    @(posedge clk);
    {t1, t2, st} <= 24'h000000;
    @(negedge clk);
  endtask

  task automatic t_regs;
    for (int i = 0; i < 3; i++)
    begin
      bus(0, 3'(i), 0);
      check(q, 0);
    end
    bus(1, 3'h0, 32'hFFFFFFFF);
    bus(1, 3'h1, 32'h000000FF);
    bus(1, 3'h6, 32'h12345678);
    bus(0, 3'h6, 0);
    check(q, 32'h0);
    bus(0, 3'h0, 0);
    check(q, 32'h0000FFFF);
    bus(0, 3'h1, 0);
    check(q, 32'h00000080);
  endtask

  task automatic t_stop;
    for (int k = 0; k < 8; k++)
    begin
      pulse(8'h01 << k, 0, 0, 0, 16'hFFFF);
      check(sclr, 16'h0001 << k);
      check(cclr, 16'h0001 << k);
      pulse(0, 8'h01 << k, 0, 0, 16'hFFFF);
      check(sclr, 16'h0100 << k);
    end
    pulse(8'hFF, 8'hFF, 0, 0, 16'h0000);
    check(sclr, 0);
    bus(1, 3'h0, 32'h00000000);
    pulse(8'hFF, 8'hFF, 0, 0, 16'hFFFF);
    check(sclr, 0);
  endtask

  task automatic t_irq;
    bus(1, 3'h4, 0);
    bus(1, 3'h3, 32'hFFFF);
    bus(1, 3'h0, 32'h0008);
    pulse(8'h08, 0, 0, 0, 16'hFFFF);
    bus(0, 3'h3, 0);
    check(q, 32'h0008);
    check(irq, 0);
    bus(1, 3'h4, 32'h0008);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(irq, 1);
    bus(1, 3'h3, 32'h0008);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(irq, 0);
  endtask

  task automatic t_reload;
    bus(1, 3'h2, 32'hA5C3);
    bus(1, 3'h1, 32'h80);
    @(negedge clk);
    check(rval, 16'hA5C3);
    for (int k = 0; k < 8; k++)
    begin
      pulse(0, 0, 8'h01 << k, 8'hFF, 0);
      check(load, 8'h01 << k);
    end
    pulse(0, 0, 8'hFF, 8'h5A, 16'h0F00);
    check(load, 8'h50);
    bus(1, 3'h1, 0);
    pulse(0, 0, 8'hFF, 8'hFF, 0);
    check(load, 0);
  endtask

  // Either standby entry wipes both enable registers
  task automatic t_standby;
    for (int m = 0; m < 2; m++)
    begin
      bus(1, 3'h0, 32'hFFFF);
      bus(1, 3'h1, 32'h80);
      @(posedge clk);
      {hw_sb, sw_sb} <= m ? 2'b01 : 2'b10;
      @(posedge clk);
      {hw_sb, sw_sb} <= 2'b00;
      bus(0, 3'h0, 0);
      check(q, 0);
      bus(0, 3'h1, 0);
      check(q, 0);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_stop();
    t_irq();
    t_reload();
    t_standby();
    complete_run();
  end
endmodule // oneshot_terminate_reload_ctrl_test

bind oneshot_terminate_reload_ctrl oneshot_ctrl_properties props_i (
  .clk(clk), .rst(rst), .hw_standby(hw_standby), .sw_standby(sw_standby),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .ch1_stop_trig(ch1_stop_trig), .ch2_stop_trig(ch2_stop_trig),
  .ch2_start_trig(ch2_start_trig), .link_ch2(link_ch2),
  .down_count_start_bits(down_count_start_bits),
  .start_bit_clr(start_bit_clr), .counter_clr(counter_clr),
  .reload_load(reload_load), .irq(irq));

// ### reload_gate.sv
// Per-counter reload decision for the channel-2-linked down-counters
`timescale 1ns/1ns

module reload_gate #(
  parameter int LANES = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clr,
  input  wire logic             reload_allow,
  input  wire logic [LANES-1:0] start_trig,
  input  wire logic [LANES-1:0] link_ch2,
  input  wire logic [LANES-1:0] running,
  output      logic [LANES-1:0] load_q
);

  logic [LANES-1:0] load_d;

  // Each lane decides on its own trigger; no lane waits for another
  always_comb
  begin
    load_d = {LANES{reload_allow}} & start_trig // [RULE_06] [RULE_11]
           & link_ch2 & ~running;              // [RULE_07]
  end

  // One-cycle load strobe toward the down-counter
  always_ff @(posedge clk)
  begin
    if (rst || clr)
    begin
      load_q <= '0;
    end
    else
    begin
      load_q <= load_d;
    end
  end

endmodule // reload_gate
